/* qpp_phase_gen.sv */
// package of shared constants and types, plus the four-phase clock divider
// ============================================================================
// Notes on behaviour
// - input clock divided by four into four non-overlapping phases forming one cycle
// - program counter increments in phase one; this starts each fetch cycle
// - next program word is fetched and captured at phase four of the fetch cycle
// - captured word sits in the instruction latch for the decoder from phase one
// - latched instruction decodes and executes over phases two, three and four
// - fetch of one instruction overlaps execute of the previous; single-cycle throughput
// - data operand read in phase two, destination written in phase four
// - a taken jump flushes the prefetched word; that instruction takes two cycles
package qpp_pkg;
   // ============================================================================
   // sizes and reset values
   localparam int QPP_ADDR_W = 16;
   localparam int QPP_WORD_W = 16;
   localparam logic [QPP_ADDR_W-1:0] QPP_RESET_VECTOR = 16'h0000;
   localparam int QPP_PHASES_PER_CYCLE = 4;
   localparam int QPP_JUMP_CYCLES = 2;

   // ============================================================================
   // phase counter and one-hot phase group
   typedef enum logic [1:0] {
      QPP_PH_ONE,
      QPP_PH_TWO,
      QPP_PH_THREE,
      QPP_PH_FOUR
   } qpp_phase_e_t;

   typedef struct packed {
      logic phase_one;
      logic phase_two;
      logic phase_three;
      logic phase_four;
   } qpp_phase_t;

   // data memory strobes towards the datapath
   typedef struct packed {
      logic operand_rd;
      logic dest_wr;
      logic exec_en;
   } qpp_dmem_t;
endpackage

`timescale 1ns/1ps

// ============================================================================
// phase divider
module qpp_phase_gen
(
   input wire logic i_ref_clk,
   input wire logic i_srst,
   output qpp_pkg::qpp_phase_t o_phase
);
   import qpp_pkg::*;

   typedef struct packed {
      qpp_phase_e_t cnt;
      qpp_phase_t phase;
   } qpp_gen_state_t;

   qpp_gen_state_t st_r;
   qpp_gen_state_t st_nxt;

   // advance one phase per input clock, wrap after four
   always_comb
   begin
      st_nxt = st_r;
      unique case (st_r.cnt)
         QPP_PH_ONE: st_nxt.cnt = QPP_PH_TWO;
         QPP_PH_TWO: st_nxt.cnt = QPP_PH_THREE;
         QPP_PH_THREE: st_nxt.cnt = QPP_PH_FOUR;
         QPP_PH_FOUR: st_nxt.cnt = QPP_PH_ONE;
      endcase
      // exactly one phase high, so phases never overlap
      st_nxt.phase.phase_one = (st_nxt.cnt == QPP_PH_ONE);
      st_nxt.phase.phase_two = (st_nxt.cnt == QPP_PH_TWO);
      st_nxt.phase.phase_three = (st_nxt.cnt == QPP_PH_THREE);
      st_nxt.phase.phase_four = (st_nxt.cnt == QPP_PH_FOUR);
   end

   // reset lands in phase one so the first cycle is a clean fetch cycle
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         st_r.cnt <= QPP_PH_ONE;
         st_r.phase <= '{phase_one: 1'b1, default: 1'b0};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign o_phase = st_r.phase;
endmodule // qpp_phase_gen

/* qpp_pipeline.sv */
// two-stage fetch/execute sequencer driven by the four-phase instruction cycle
`timescale 1ns/1ps

module qpp_pipeline
#(
   parameter int ADDR_W = qpp_pkg::QPP_ADDR_W,
   parameter int WORD_W = qpp_pkg::QPP_WORD_W
)
(
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic [WORD_W-1:0] i_prog_word,
   input wire logic i_jump,
   input wire logic [ADDR_W-1:0] i_jump_target,
   output logic [ADDR_W-1:0] o_prog_addr,
   output logic o_prog_rd,
   output logic [ADDR_W-1:0] o_program_counter,
   output logic [WORD_W-1:0] o_instruction_latch,
   output logic o_instr_valid,
   output qpp_pkg::qpp_phase_t o_phase,
   output qpp_pkg::qpp_dmem_t o_dmem
);
   import qpp_pkg::*;

   typedef struct packed {
      logic [ADDR_W-1:0] program_counter;
      logic [ADDR_W-1:0] fetch_addr;
      logic [WORD_W-1:0] instruction_latch;
      logic instr_valid;
      logic prog_rd;
      qpp_dmem_t dmem;
   } qpp_core_state_t;

   qpp_core_state_t st_r;
   qpp_core_state_t st_nxt;
   qpp_phase_t ph;

   // ============================================================================
   // phase source
   qpp_phase_gen u_phase_gen
   (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .o_phase(ph)
   );

   // ============================================================================
   // sequencing
   // every action happens on the edge that closes the named phase
   always_comb
   begin
      st_nxt = st_r;
      // end of phase one: fetch address frozen, counter steps ahead
      if (ph.phase_one)
      begin
         st_nxt.fetch_addr = st_r.program_counter;
         st_nxt.program_counter = st_r.program_counter + 1'b1;
      end
      // end of phase four: fetched word enters the latch for the next cycle
      if (ph.phase_four)
      begin
         st_nxt.instruction_latch = i_prog_word;
         st_nxt.instr_valid = 1'b1;
         // a taken jump redirects the counter and drops the prefetched word
         if (st_r.instr_valid && i_jump)
         begin
            st_nxt.program_counter = i_jump_target;
            st_nxt.instr_valid = 1'b0;
         end
      end
      // strobes are registered one phase ahead so they line up with the phase
      st_nxt.prog_rd = ph.phase_three;
      st_nxt.dmem.operand_rd = ph.phase_one && st_r.instr_valid;
      st_nxt.dmem.dest_wr = ph.phase_three && st_r.instr_valid;
      st_nxt.dmem.exec_en = (ph.phase_one || ph.phase_two || ph.phase_three)
                            && st_r.instr_valid;
   end

   // latch starts empty so the first cycle after reset executes nothing
   always_ff @(posedge i_ref_clk)
   begin
      if (i_srst)
      begin
         st_r.program_counter <= ADDR_W'(QPP_RESET_VECTOR);
         st_r.fetch_addr <= ADDR_W'(QPP_RESET_VECTOR);
         st_r.instruction_latch <= '0;
         st_r.instr_valid <= 1'b0;
         st_r.prog_rd <= 1'b0;
         st_r.dmem <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ============================================================================
   // outputs, all straight from flops
   assign o_prog_addr = st_r.fetch_addr;
   assign o_prog_rd = st_r.prog_rd;
   assign o_program_counter = st_r.program_counter;
   assign o_instruction_latch = st_r.instruction_latch;
   assign o_instr_valid = st_r.instr_valid;
   assign o_phase = ph;
   assign o_dmem = st_r.dmem;
endmodule // qpp_pipeline

/* qpp_pipeline_assertions.sv */
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
module qpp_pipeline_assertions
(
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic i_jump,
   input wire logic [15:0] i_jump_target,
   input wire logic [15:0] o_prog_addr,
   input wire logic o_prog_rd,
   input wire logic [15:0] o_program_counter,
   input wire logic [15:0] o_instruction_latch,
   input wire logic o_instr_valid,
   input wire qpp_pkg::qpp_phase_t o_phase,
   input wire qpp_pkg::qpp_dmem_t o_dmem
);
   import qpp_pkg::*;
   // ==========================================================================
   // phase order, fetch timing, strobes and flush
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);
   a_phase_onehot: assert property ($onehot(o_phase)) else $error("phase");
   a_phase_rotate: assert property (o_phase.phase_one |=> o_phase.phase_two)
      else $error("rotate");
   a_count_step: assert property (o_phase.phase_two |->
      o_program_counter == o_prog_addr + 16'h0001) else $error("pc");
   a_fetch_strobe: assert property (o_prog_rd == o_phase.phase_four)
      else $error("rd");
   a_latch_hold: assert property (o_phase.phase_one |=>
      $stable(o_instruction_latch)[*3]) else $error("latch");
   a_exec_span: assert property (o_dmem.exec_en == (o_instr_valid && !o_phase.phase_one))
      else $error("exec");
   a_operand_read: assert property (o_dmem.operand_rd ==
      (o_instr_valid && o_phase.phase_two)) else $error("opnd");
   a_dest_write: assert property (o_dmem.dest_wr == (o_instr_valid && o_phase.phase_four))
      else $error("dest");
   // a taken jump empties one whole cycle and loads the target
   a_jump_flush: assert property (o_phase.phase_four && o_instr_valid && i_jump |=>
      !o_instr_valid && o_program_counter == $past(i_jump_target) ##3 !o_instr_valid)
      else $error("flush");
   cover property (o_dmem.dest_wr);
   cover property (o_phase.phase_four && o_instr_valid && i_jump);
   cover property ($rose(o_instr_valid));
endmodule // qpp_pipeline_assertions

/* qpp_prog_model.sv */
// program memory model
`timescale 1ns/1ps
module qpp_prog_model
(
   input wire logic [15:0] i_prog_addr,
   input wire logic i_prog_rd,
   output logic [15:0] o_prog_word
);
   // ==========================================================================
   // not read means not driven, so show the inverse rather than a stale word
   assign o_prog_word = (i_prog_addr ^ 16'h5a3c) ^ {16{!i_prog_rd}};
endmodule // qpp_prog_model

/* testbench.sv */
// self-checking bench for the sequencer
`timescale 1ns/1ps
module testbench;
   import qpp_pkg::*;
   logic i_ref_clk = 1'b0;
   logic i_srst = 1'b1;
   logic i_jump = 1'b0;
   logic [15:0] i_jump_target = 16'h0000, i_prog_word, o_prog_addr, o_program_counter;
   logic [15:0] o_instruction_latch, m_pc = 16'h0000, m_a, m_l;
   logic o_prog_rd, o_instr_valid, m_v = 1'b0;
   qpp_phase_t o_phase;
   qpp_dmem_t o_dmem;
   int failures = 0, cmp_count = 0, cyc = 0;
   logic [31:0] rnd = 32'h67bc_7701;
   // ==========================================================================
   // clock, design and memory
   always #50 i_ref_clk = ~i_ref_clk;
   qpp_pipeline u_dut (.i_ref_clk, .i_srst, .i_prog_word, .i_jump, .i_jump_target,
      .o_prog_addr, .o_prog_rd, .o_program_counter, .o_instruction_latch, .o_instr_valid,
      .o_phase, .o_dmem);
   qpp_prog_model u_mem (.i_prog_addr(o_prog_addr), .i_prog_rd(o_prog_rd),
      .o_prog_word(i_prog_word));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // hang guard: about 350 cycles expected over both passes
   always @(posedge i_ref_clk)
   begin
      cyc++;
      if (cyc > 1000)
      begin
         failures++;
         final_report();
      end
   end
   // ==========================================================================
   // one loop turn per instruction cycle, 40 per pass; jumps are random, some while empty
   task automatic run_walk();
      repeat (10) @(negedge i_ref_clk);
      i_srst = 1'b0;
      // model restarts with the design: counter at the vector, latch empty
      m_pc = QPP_RESET_VECTOR;
      m_v = 1'b0;
      repeat (40)
      begin
         chk({12'h000, o_phase}, 16'h0008);
         chk({12'h000, o_dmem, o_prog_rd}, 16'h0000);
         chk(o_program_counter, m_pc);
         chk({15'h0000, o_instr_valid}, {15'h0000, m_v});
         if (m_v)
            chk(o_instruction_latch, m_l);
         @(negedge i_ref_clk);
         m_a = m_pc;
         m_pc = m_pc + 16'h0001;
         chk(o_prog_addr, m_a);
         chk(o_program_counter, m_pc);
         chk({13'h0000, o_dmem}, {13'h0000, m_v, 1'b0, m_v});
         chk({12'h000, o_phase}, 16'h0004);
         rnd = lfsr(rnd);
         i_jump = rnd[0]; // off-phase request must be ignored
         repeat (2) @(negedge i_ref_clk);
         chk({12'h000, o_dmem, o_prog_rd}, {12'h000, 1'b0, m_v, m_v, 1'b1});
         chk({12'h000, o_phase}, 16'h0001);
         rnd = lfsr(rnd);
         i_jump = (rnd[2:1] == 2'b00);
         i_jump_target = rnd[31:16];
         if (i_jump && m_v)
         begin
            m_pc = i_jump_target;
            m_v = 1'b0;
         end
         else
         begin
            m_v = 1'b1;
            m_l = m_a ^ 16'h5a3c;
         end
         @(negedge i_ref_clk);
      end
      $display("pipeline walk done");
   endtask
   // first pass from power-up, second after a reset dropped in mid-cycle
   initial
   begin
      run_walk();
      // reset lands in phase three while a word is latched and executing
      repeat (2) @(negedge i_ref_clk);
      i_srst = 1'b1;
      i_jump = 1'b0;
      run_walk();
      final_report();
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
endmodule // testbench
bind qpp_pipeline qpp_pipeline_assertions u_chk (.i_ref_clk, .i_srst, .i_jump, .i_jump_target,
   .o_prog_addr, .o_prog_rd, .o_program_counter, .o_instruction_latch, .o_instr_valid,
   .o_phase, .o_dmem);
